// ---- rtl/crb_accept.sv ----
// Purpose: per-buffer acceptance decision from the receive-mode bits
// Assumes: message attributes valid while offer is high
// Notes:   pure combinational, one copy per buffer
`timescale 1ns/1ns
`default_nettype none
module crb_accept (
   input  wire logic       legacy,
   input  wire logic [1:0] mode_field,
   input  wire logic       msg_ok,
   input  wire logic       msg_ext,
   input  wire logic       filt_hit,
   input  wire logic       filt_ext_en,
   output logic            accept
);
   `include "crb_map.svh"

   // decide whether the buffer takes the message
   always_comb begin
      accept = 1'b0;
      if (legacy) begin
         case (mode_field)
            // everything, errors too, filters ignored
            `CRB_RXM_ALL:   accept = 1'b1;
            // valid extended only
            `CRB_RXM_EXT:   accept = msg_ok && filt_hit && msg_ext && filt_ext_en;
            // valid standard only
            `CRB_RXM_STD:   accept = msg_ok && filt_hit && !msg_ext && !filt_ext_en;
            // valid, type as the filter's own enable bit says
            `CRB_RXM_VALID: accept = msg_ok && filt_hit && (msg_ext == filt_ext_en);
            default:        accept = 1'b0;
         endcase
      end else begin
         // single mode bit: all, or valid filter-accepted
         accept = mode_field[1] ? 1'b1 : (msg_ok && filt_hit);
      end
   end
endmodule
`default_nettype wire

// ---- rtl/crb_ctrl.sv ----
// Purpose: receive buffer full flags, mode bits, hit reporting, overflow, interrupt
// Assumes: protocol engine offers one message per offer pulse on clk_sys
// Notes:   registers on a plain port, read data one cycle after the read strobe
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module crb_ctrl (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // message offer from the protocol engine
   input  wire logic       msg_offer,
   input  wire logic       msg_ok,
   input  wire logic       msg_ext,
   input  wire logic       msg_rtr,
   input  wire logic       msg_filt_hit,
   input  wire logic [4:0] msg_filt_idx,
   input  wire logic       msg_filt_ext_en,
   // status outputs
   output logic            buf0_load,
   output logic            buf1_load,
   output logic            irq
);
   `include "crb_map.svh"

   ////////////////////////////////////////////////////////////////////////////////
   // state
   crb_pkg::crb_opmode_t opmode_ff;     // module operating mode
   logic [1:0]  mode0_ff;               // buffer 0 receive-mode field
   logic [1:0]  mode1_ff;               // buffer 1 receive-mode field
   logic        full0_ff;               // buffer 0 full flag
   logic        full1_ff;               // buffer 1 full flag
   logic        rtr0_ff;                // buffer 0 remote request seen
   logic        rtr1_ff;                // buffer 1 remote request seen
   logic [4:0]  hit0_ff;                // buffer 0 filter hit index
   logic [4:0]  hit1_ff;                // buffer 1 filter hit index
   logic        dbl_en_ff;              // legacy double-buffer enable
   logic [2:0]  irq_stat_ff;            // sticky event bits
   logic [2:0]  irq_mask_ff;            // interrupt enables
   logic [7:0]  nxt_rdata;              // read mux result
   logic        legacy;                 // legacy layout active
   logic        acc0;                   // buffer 0 would accept
   logic        acc1;                   // buffer 1 would accept
   logic        acc0_dbl;               // buffer 0 would accept in legacy double mode
   logic        fil_b1_legal;           // legacy buffer 1 index in range
   crb_pkg::crb_dest_t dest;            // chosen destination
   logic        wr_b0;                  // software write to buffer 0 control
   logic        wr_b1;                  // software write to buffer 1 control
   logic        wr_stat;                // software write to status

   assign legacy  = (opmode_ff == crb_pkg::CRB_MODE_LEGACY);
   assign wr_b0   = reg_wr && (reg_addr == `CRB_OFF_BUF0_CTRL);
   assign wr_b1   = reg_wr && (reg_addr == `CRB_OFF_BUF1_CTRL);
   assign wr_stat = reg_wr && (reg_addr == `CRB_OFF_IRQ_STATUS);

   ////////////////////////////////////////////////////////////////////////////////
   // acceptance per buffer
   crb_accept u_acc0 (
      .legacy      (legacy),
      .mode_field  (mode0_ff),
      .msg_ok      (msg_ok),
      .msg_ext     (msg_ext),
      .filt_hit    (msg_filt_hit),
      .filt_ext_en (msg_filt_ext_en),
      .accept      (acc0)
   );
   crb_accept u_acc1 (
      .legacy      (legacy),
      .mode_field  (mode1_ff),
      .msg_ok      (msg_ok),
      .msg_ext     (msg_ext),
      .filt_hit    (msg_filt_hit),
      .filt_ext_en (msg_filt_ext_en),
      .accept      (acc1)
   );

   // in legacy mode filters 0 and 1 belong to buffer 0, filters 2..5 to buffer 1
   assign fil_b1_legal = (msg_filt_idx[2:0] <= `CRB_MAX_LEG_B1) && (msg_filt_idx[4:3] == 2'h0);
   assign acc0_dbl     = acc0 && (msg_filt_idx[4:1] == 4'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // destination choice
   always_comb begin
      dest = crb_pkg::CRB_DEST_NONE;
      if (msg_offer) begin
         if (legacy) begin
            if (acc0_dbl || (mode0_ff == `CRB_RXM_ALL)) begin
               if (!full0_ff) begin
                  dest = crb_pkg::CRB_DEST_B0;
               end else if (dbl_en_ff && !full1_ff) begin
                  dest = crb_pkg::CRB_DEST_B1;          // overflow into buffer 1
               end else begin
                  dest = crb_pkg::CRB_DEST_NONE;
               end
            end else if (acc1 && fil_b1_legal && (msg_filt_idx[2:1] != 2'h0) && !full1_ff) begin
               dest = crb_pkg::CRB_DEST_B1;             // filters 2..5 only
            end else begin
               dest = crb_pkg::CRB_DEST_NONE;
            end
         end else begin
            // enhanced: buffer 0 first, then buffer 1; full buffers skipped
            if (acc0 && !full0_ff && (msg_filt_idx <= `CRB_MAX_FILTER)) begin
               dest = crb_pkg::CRB_DEST_B0;
            end else if (acc1 && !full1_ff && (msg_filt_idx <= `CRB_MAX_FILTER)) begin
               dest = crb_pkg::CRB_DEST_B1;
            end else begin
               dest = crb_pkg::CRB_DEST_NONE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // operating mode, from software
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         opmode_ff <= crb_pkg::CRB_MODE_LEGACY;
      end else if (reg_wr && (reg_addr == `CRB_OFF_OP_MODE)) begin
         case (reg_wdata[1:0])
            2'h1:    opmode_ff <= crb_pkg::CRB_MODE_ENH1;
            2'h2:    opmode_ff <= crb_pkg::CRB_MODE_ENH2;
            default: opmode_ff <= crb_pkg::CRB_MODE_LEGACY;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // receive-mode bits and double-buffer enable
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mode0_ff  <= `CRB_RST_MODE;
         mode1_ff  <= `CRB_RST_MODE;
         dbl_en_ff <= 1'b0;
      end else begin
         if (wr_b0) begin
            // low mode bit only writable in legacy layout
            mode0_ff[1] <= reg_wdata[`CRB_BIT_MODE_HI];
            if (legacy) begin
               mode0_ff[0] <= reg_wdata[`CRB_BIT_MODE_LO];
               dbl_en_ff   <= reg_wdata[`CRB_BIT_DBL_EN];
            end
         end
         if (wr_b1) begin
            mode1_ff[1] <= reg_wdata[`CRB_BIT_MODE_HI];
            if (legacy) begin
               mode1_ff[0] <= reg_wdata[`CRB_BIT_MODE_LO];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // full flags: hardware sets, software clears by writing zero; set wins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         full0_ff <= 1'b0;
         full1_ff <= 1'b0;
      end else begin
         if (dest == crb_pkg::CRB_DEST_B0) begin
            full0_ff <= 1'b1;
         end else if (wr_b0 && !reg_wdata[`CRB_BIT_FULL]) begin
            full0_ff <= 1'b0;                                  // clear only
         end
         if (dest == crb_pkg::CRB_DEST_B1) begin
            full1_ff <= 1'b1;
         end else if (wr_b1 && !reg_wdata[`CRB_BIT_FULL]) begin
            full1_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // captured message attributes; held until the next load
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rtr0_ff <= 1'b0;
         rtr1_ff <= 1'b0;
         hit0_ff <= 5'h00;
         hit1_ff <= 5'h00;
      end else begin
         if (dest == crb_pkg::CRB_DEST_B0) begin
            rtr0_ff <= msg_rtr;
            hit0_ff <= msg_filt_idx;
         end
         if (dest == crb_pkg::CRB_DEST_B1) begin
            rtr1_ff <= msg_rtr;
            // an overflow that ignored the filters must not show a reserved code
            if (legacy && !fil_b1_legal) begin
               hit1_ff <= {4'h0, msg_filt_idx[0]};
            end else begin
               hit1_ff <= msg_filt_idx;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // load pulses out
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         buf0_load <= 1'b0;
         buf1_load <= 1'b0;
      end else begin
         buf0_load <= (dest == crb_pkg::CRB_DEST_B0);
         buf1_load <= (dest == crb_pkg::CRB_DEST_B1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status: set wins over write-one-to-clear
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_stat_ff <= 3'h0;
      end else begin
         // buffer 0 flag comes back while its full flag stays set
         irq_stat_ff[`CRB_IRQ_B0] <= (dest == crb_pkg::CRB_DEST_B0) || full0_ff ||
                                    (irq_stat_ff[`CRB_IRQ_B0] && !(wr_stat && reg_wdata[`CRB_IRQ_B0]));
         irq_stat_ff[`CRB_IRQ_B1] <= (dest == crb_pkg::CRB_DEST_B1) ||
                                    (irq_stat_ff[`CRB_IRQ_B1] && !(wr_stat && reg_wdata[`CRB_IRQ_B1]));
         // accepted message dropped because every target was full
         irq_stat_ff[`CRB_IRQ_LOST] <= (msg_offer && (dest == crb_pkg::CRB_DEST_NONE) &&
                                      ((acc0 && full0_ff) || (acc1 && full1_ff))) ||
                                      (irq_stat_ff[`CRB_IRQ_LOST] && !(wr_stat && reg_wdata[`CRB_IRQ_LOST]));
      end
   end

   // mask register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_mask_ff <= 3'h0;
      end else if (reg_wr && (reg_addr == `CRB_OFF_IRQ_MASK)) begin
         irq_mask_ff <= reg_wdata[2:0];
      end
   end

   // level interrupt, registered: one cycle behind the status
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux; layout follows the operating mode
   always_comb begin
      nxt_rdata = `CRB_RST_BYTE;
      case (reg_addr)
         `CRB_OFF_BUF0_CTRL: begin
            if (legacy) begin
               // bit 4 stays zero jump bit mirrors the enable
               nxt_rdata = {full0_ff, mode0_ff, 1'b0, rtr0_ff, dbl_en_ff, dbl_en_ff, hit0_ff[0]};
            end else begin
               nxt_rdata = {full0_ff, mode0_ff[1], rtr0_ff, hit0_ff};
            end
         end
         `CRB_OFF_BUF1_CTRL: begin
            if (legacy) begin
               nxt_rdata = {full1_ff, mode1_ff, 1'b0, rtr1_ff, hit1_ff[2:0]};
            end else begin
               nxt_rdata = {full1_ff, mode1_ff[1], rtr1_ff, hit1_ff};
            end
         end
         `CRB_OFF_IRQ_STATUS: nxt_rdata = {5'h00, irq_stat_ff};
         `CRB_OFF_IRQ_MASK:   nxt_rdata = {5'h00, irq_mask_ff};
         `CRB_OFF_OP_MODE:    nxt_rdata = {6'h00, opmode_ff};
         default:             nxt_rdata = `CRB_RST_BYTE;   // unmapped reads zero
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= `CRB_RST_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= nxt_rdata;
      end else begin
         reg_rdata <= `CRB_RST_BYTE;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/crb_map.svh ----
// Purpose: offsets, field positions and reset values of the receive buffer control block
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CRB_MAP_SVH
`define CRB_MAP_SVH

// register offsets on the plain port
`define CRB_OFF_BUF0_CTRL   4'h0
`define CRB_OFF_BUF1_CTRL   4'h1
`define CRB_OFF_IRQ_STATUS  4'h2
`define CRB_OFF_IRQ_MASK    4'h3
`define CRB_OFF_OP_MODE     4'h4

// control register field positions
`define CRB_BIT_FULL        7
`define CRB_BIT_MODE_HI     6
`define CRB_BIT_MODE_LO     5
`define CRB_BIT_RTR_ENH     5
`define CRB_BIT_UNIMPL      4
`define CRB_BIT_RTR_LEG     3
`define CRB_BIT_DBL_EN      2
`define CRB_BIT_JUMP        1

// receive-mode field codes in legacy mode
`define CRB_RXM_ALL         2'h3
`define CRB_RXM_EXT         2'h2
`define CRB_RXM_STD         2'h1
`define CRB_RXM_VALID       2'h0

// highest filter index a hit may name in the enhanced modes
`define CRB_MAX_FILTER      5'hF
// highest filter index buffer 1 may name in legacy mode
`define CRB_MAX_LEG_B1      3'h5

// interrupt status bits
`define CRB_IRQ_B0          0
`define CRB_IRQ_B1          1
`define CRB_IRQ_LOST        2

// reset values
`define CRB_RST_BYTE        8'h00
`define CRB_RST_MODE        2'h0

`endif

// ---- rtl/crb_pkg.sv ----
// Purpose: types of the receive buffer control block
// Assumes: nothing
// Notes:   numbers live in crb_map.svh
package crb_pkg;
   // module operating mode, set by a software write to the op mode register
   typedef enum logic [1:0] {
      CRB_MODE_LEGACY = 2'h0,
      CRB_MODE_ENH1   = 2'h1,
      CRB_MODE_ENH2   = 2'h2
   } crb_opmode_t;
   // where an offered message goes
   typedef enum logic [1:0] {
      CRB_DEST_NONE = 2'h0,
      CRB_DEST_B0   = 2'h1,
      CRB_DEST_B1   = 2'h2
   } crb_dest_t;
endpackage

// ---- verification/crb_ctrl_sva.sv ----
// Purpose: port-level checks of the receive buffer control block
// Assumes: bound to crb_ctrl from the bench top file
// Notes:   full, mask and layout shadows are rebuilt from port traffic only
`timescale 1ns/1ns
`default_nettype none
module crb_ctrl_sva (
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       msg_offer,
   input wire logic       msg_ok,
   input wire logic       msg_ext,
   input wire logic       msg_rtr,
   input wire logic       msg_filt_hit,
   input wire logic [4:0] msg_filt_idx,
   input wire logic       msg_filt_ext_en,
   input wire logic       buf0_load,
   input wire logic       buf1_load,
   input wire logic       irq
);
   logic       full0_ff;  // buffer 0 seen loaded, not yet cleared
   logic       full1_ff;  // buffer 1 seen loaded, not yet cleared
   logic [2:0] mask_ff;   // copy of the low mask bits
   logic       leg_ff;    // legacy layout in force

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////////
   // full shadows: a clear write wins, since the design flag set one edge earlier
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         full0_ff <= 1'b0;
         full1_ff <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 4'h0 && !reg_wdata[7]) full0_ff <= 1'b0;
         else if (buf0_load) full0_ff <= 1'b1;
         if (reg_wr && reg_addr == 4'h1 && !reg_wdata[7]) full1_ff <= 1'b0;
         else if (buf1_load) full1_ff <= 1'b1;
      end
   end

   // mask and layout shadows; mode 3 counts as legacy
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mask_ff <= 3'h0;
         leg_ff  <= 1'b1;
      end else begin
         if (reg_wr && reg_addr == 4'h3) mask_ff <= reg_wdata[2:0];
         if (reg_wr && reg_addr == 4'h4) leg_ff <= (reg_wdata[1:0] == 2'h0) || (reg_wdata[1:0] == 2'h3);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_full0_armed;
      full0_ff && mask_ff[0];
   endsequence

   AST_ONE_DEST: assert property (!(buf0_load && buf1_load))
      else $error("one offer loaded both buffers");
   AST_LOAD_CAUSE: assert property ((buf0_load || buf1_load) |-> $past(msg_offer))
      else $error("load pulse without an offer");
   AST_FULL0_HOLD: assert property (buf0_load |-> !full0_ff)
      else $error("buffer 0 loaded while full");
   AST_FULL1_HOLD: assert property (buf1_load |-> !full1_ff)
      else $error("buffer 1 loaded while full");
   AST_LOAD_IRQ: assert property (buf0_load && mask_ff[0] |=> irq)
      else $error("no interrupt after unmasked load");
   AST_IRQ_REARM: assert property (s_full0_armed ##1 s_full0_armed |-> irq)
      else $error("interrupt dropped while buffer 0 full");
   AST_IRQ_QUIET: assert property (mask_ff == 3'h0 |=> !irq)
      else $error("interrupt with all sources masked");
   AST_BIT4_ZERO: assert property (reg_rd && reg_addr <= 4'h1 && leg_ff |=> reg_rdata[4] == 1'b0)
      else $error("legacy bit 4 read as one");
   AST_JUMP_COPY: assert property (reg_rd && reg_addr == 4'h0 && leg_ff |=> reg_rdata[1] == reg_rdata[2])
      else $error("jump offset bit differs from double enable");
   AST_B1_HIT: assert property (reg_rd && reg_addr == 4'h1 && leg_ff |=> reg_rdata[2:0] <= 3'h5)
      else $error("reserved buffer 1 hit code");
endmodule
`default_nettype wire

// ---- verification/tb_can_receive_buffer_control.sv ----
// Purpose: self-checking bench of the receive buffer control block
// Assumes: crb_pkg compiled first
// Notes:   drivers note expectations in queues, one watcher compares
`timescale 1ns/1ns
`default_nettype none
module tb_can_receive_buffer_control;
   logic               clk_sys, srst, reg_wr, reg_rd, msg_offer, msg_ok, msg_ext, msg_rtr;
   logic               msg_filt_hit, msg_filt_ext_en, buf0_load, buf1_load, irq;
   logic [3:0]         reg_addr;
   logic [7:0]         reg_wdata, reg_rdata;
   logic [4:0]         msg_filt_idx, idx;
   logic               rd_d, of_d, irq_probe, rtr;
   logic [7:0]         exp_b[$];   // pending read data
   crb_pkg::crb_dest_t exp_d[$];   // pending load destinations
   logic               exp_i[$];   // pending irq levels
   logic [8:0]         tbl [8];    // {mode, ok ext rtr hit fe, dest}
   int                 err_count, checks;

   crb_ctrl crb_ctrl_i (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_offer(msg_offer), .msg_ok(msg_ok),
      .msg_ext(msg_ext), .msg_rtr(msg_rtr), .msg_filt_hit(msg_filt_hit), .msg_filt_idx(msg_filt_idx),
      .msg_filt_ext_en(msg_filt_ext_en), .buf0_load(buf0_load), .buf1_load(buf1_load), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp_b(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_d(input crb_pkg::crb_dest_t got, input crb_pkg::crb_dest_t exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_i(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      // a noted result that never showed up counts as a mismatch
      if (exp_b.size() + exp_d.size() + exp_i.size() != 0) err_count++;
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // drivers: wait an edge first so no strobe is assigned twice in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_b.push_back(e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   // f packs ok, ext, rtr, hit, filter ext enable; fields go random when idle
   task automatic offer(input logic [4:0] f, input logic [4:0] i, input crb_pkg::crb_dest_t d);
      exp_d.push_back(d);
      @(posedge clk_sys);
      {msg_ok, msg_ext, msg_rtr, msg_filt_hit, msg_filt_ext_en} <= f;
      msg_filt_idx <= i;
      msg_offer    <= 1'b1;
      @(posedge clk_sys);
      msg_offer <= 1'b0;
      {msg_ok, msg_ext, msg_rtr, msg_filt_hit, msg_filt_ext_en} <= 5'($urandom);
      msg_filt_idx <= 5'($urandom);
   endtask
   task automatic chk_irq(input logic e);
      exp_i.push_back(e);
      @(posedge clk_sys);
      irq_probe <= 1'b1;
      @(posedge clk_sys);
      irq_probe <= 1'b0;
   endtask

   // watcher: read data one cycle after the strobe, load pulse one after offer
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
      of_d <= msg_offer;
      if (rd_d && exp_b.size() > 0) cmp_b(reg_rdata, exp_b.pop_front());
      if (of_d && exp_d.size() > 0) cmp_d(crb_pkg::crb_dest_t'({buf1_load, buf0_load}), exp_d.pop_front());
      if (irq_probe && exp_i.size() > 0) cmp_i(irq, exp_i.pop_front());
   end

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // watchdog, far beyond the 185 or so cycles the sequence needs
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {srst, reg_wr, reg_rd, msg_offer, msg_ok, msg_ext, msg_rtr, msg_filt_hit, msg_filt_ext_en} = 9'h100;
      {reg_addr, reg_wdata, msg_filt_idx, rd_d, of_d, irq_probe} = 20'h00000;
      err_count = 0;
      checks = 0;
      rtr = 1'($urandom(32'h4b69e157));
      tbl = '{9'b11_00000_01, 9'b10_11011_01, 9'b10_10010_00, 9'b01_10010_01,
              9'b01_11011_00, 9'b00_11011_01, 9'b00_00010_00, 9'b00_10000_00};
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      for (int k = 0; k < 6; k++) rd((k == 5) ? 4'hA : 4'(k), 8'h00);
      wr(4'h0, 8'hFF);
      rd(4'h0, 8'h66);
      wr(4'h1, 8'hFF);
      rd(4'h1, 8'h60);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
      wr(4'h3, 8'h07);
      // load, refuse while full, interrupt re-set until full clears
      offer(5'b10110, 5'h01, crb_pkg::CRB_DEST_B0);
      rd(4'h0, 8'h89);
      offer(5'b10010, 5'h00, crb_pkg::CRB_DEST_NONE);
      rd(4'h2, 8'h05);
      wr(4'h2, 8'h05);
      rd(4'h2, 8'h01);
      chk_irq(1'b1);
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h01);
      rd(4'h2, 8'h00);
      chk_irq(1'b0);
      // every legacy mode code on buffer 0
      foreach (tbl[k]) begin
         wr(4'h0, {1'b0, tbl[k][8:7], 5'h00});
         offer(tbl[k][6:2], 5'h00, crb_pkg::crb_dest_t'(tbl[k][1:0]));
      end
      // overflow into buffer 1 with double buffering on
      wr(4'h0, 8'h04);
      offer(5'b10010, 5'h00, crb_pkg::CRB_DEST_B0);
      rd(4'h0, 8'h86);
      rtr = 1'($urandom);
      offer({2'b10, rtr, 2'b10}, 5'h01, crb_pkg::CRB_DEST_B1);
      rd(4'h1, {4'h8, rtr, 3'h1});
      offer(5'b10010, 5'h00, crb_pkg::CRB_DEST_NONE);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
      rd(4'h2, 8'h07);
      // legacy buffer 1 hit codes for filters 2 to 5
      for (int k = 2; k < 6; k++) begin
         rtr = 1'($urandom);
         offer({2'b10, rtr, 2'b10}, 5'(k), crb_pkg::CRB_DEST_B1);
         rd(4'h1, {4'h8, rtr, 3'(k)});
         wr(4'h1, 8'h00);
      end
      // both enhanced modes: layout, five-bit hit, single mode bit
      for (int k = 1; k < 3; k++) begin
         wr(4'h4, 8'(k));
         idx = 5'($urandom_range(15));
         rtr = 1'($urandom);
         offer({2'b10, rtr, 2'b10}, idx, crb_pkg::CRB_DEST_B0);
         rd(4'h0, {2'b10, rtr, idx});
         offer({2'b10, ~rtr, 2'b10}, 5'h0F, crb_pkg::CRB_DEST_B1);
         rd(4'h1, {2'b10, ~rtr, 5'h0F});
         wr(4'h0, 8'h40);
         wr(4'h1, 8'h00);
         offer(5'b00000, idx, crb_pkg::CRB_DEST_B0);
         offer(5'b00000, idx, crb_pkg::CRB_DEST_NONE);
         wr(4'h0, 8'h00);
      end
      // mode code 3 falls back to the legacy layout
      wr(4'h4, 8'h03);
      rd(4'h4, 8'h00);
      // reset in mid-run while a buffer holds a message
      offer(5'b10010, 5'h00, crb_pkg::CRB_DEST_B0);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      rd(4'h4, 8'h00);
      rd(4'h0, 8'h00);
      chk_irq(1'b0);
      repeat (4) @(posedge clk_sys);
      test_done();
   end
endmodule

bind crb_ctrl crb_ctrl_sva crb_ctrl_sva_i (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_offer(msg_offer),
   .msg_ok(msg_ok), .msg_ext(msg_ext), .msg_rtr(msg_rtr), .msg_filt_hit(msg_filt_hit),
   .msg_filt_idx(msg_filt_idx), .msg_filt_ext_en(msg_filt_ext_en), .buf0_load(buf0_load),
   .buf1_load(buf1_load), .irq(irq));
`default_nettype wire
